// File: core/lgc_pkg.sv
// Constants, types and shared helpers for the login common-features codec.
// Assumes one 20 MHz clock shared by both ends of the login link.
package lgc_pkg;
    localparam int CLK_MHZ = 20;
    localparam int CLK_NS = 50;
    localparam int MS_US = 1000;
    localparam int RTTOV_LONG_US = 100000;
    localparam int RTTOV_SHORT_US = 100;
    localparam int MS_CYC = MS_US * CLK_MHZ;
    localparam int RTTOV_LONG_CYC = RTTOV_LONG_US * CLK_MHZ;
    localparam int RTTOV_SHORT_CYC = RTTOV_SHORT_US * CLK_MHZ;

    // Word 1 feature bit positions and the class 0 priority bit; some positions carry two meanings
    localparam int B_CREDIT = 27;
    localparam int B_NS_START = 27;
    localparam int B_NS_BEGIN = 26;
    localparam int B_EDTOV_RES = 26;
    localparam int B_APP_HDR = 24;
    localparam int B_BCAST = 24;
    localparam int B_PRIO_TAG = 23;
    localparam int B_QBC = 22;
    localparam int B_CLK_SYNC = 20;
    localparam int B_RTTOV = 19;
    localparam int B_DHD = 18;
    localparam int B_SEQ_CNT = 17;
    localparam int B_PAYLOAD = 16;
    localparam int B_CLS_PRIO = 23;
    localparam logic [31:0] FEAT_MASK = 32'h0fff_0000;

    localparam int PAY_SHORT = 116;
    localparam int PAY_LONG_BASE = 256;
    localparam int EXT_W = 16;
    localparam int PAY_W = 19;

    // Register offsets
    localparam int A_CTRL = 32'h00;
    localparam int A_CFG = 32'h04;
    localparam int A_EDTOV = 32'h08;
    localparam int A_STATUS = 32'h0c;
    localparam int A_PAYLEN = 32'h10;
    localparam int A_EXTLEN = 32'h14;
    localparam int A_XCHG = 32'h18;

    // Control bits (write pulses) and the priority field
    localparam int C_FLOGI = 0;
    localparam int C_PLOGI = 1;
    localparam int C_RTTOV = 2;
    localparam int C_EDTOV = 3;
    localparam int C_XSTART = 4;
    localparam int C_SEQ = 5;
    localparam int C_TX = 6;
    localparam int C_CLR = 8;
    localparam int C_PRIO = 16;

    // Config bits outside the word 1 feature field
    localparam int CFG_CLS_PRIO = 0;
    localparam int CFG_RPBC = 1;
    localparam int CFG_ELS_DIFF = 2;
    localparam int CFG_MF_UNSUP = 3;
    localparam int CFG_NS_GRANT = 4;

    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    localparam logic [31:0] EDTOV_RST = 32'h0000_07d0;
    localparam logic [15:0] EXT_RST = 16'h0000;

    typedef enum logic [1:0] {
        K_FLOGI_REQ = 2'h0,
        K_PLOGI_REQ = 2'h1,
        K_FLOGI_ACC = 2'h2,
        K_PLOGI_ACC = 2'h3
    } lgc_kind_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } lgc_state_t;

    function automatic logic [PAY_W-1:0] lgc_pay_len(input logic pbit,
                                                      input logic [EXT_W-1:0] ext);
        if (pbit)
            return PAY_W'(PAY_LONG_BASE) + {1'b0, ext, 2'b00};
        return PAY_W'(PAY_SHORT);
    endfunction

    // Accept word 1 built from local features and the request it answers
    function automatic logic [31:0] lgc_make_acc(input logic flogi,
                                                 input logic [31:0] base,
                                                 input logic [31:0] req,
                                                 input logic grant,
                                                 input logic cls_prio);
        logic [31:0] r;
        r = base;
        if (flogi)
            r[B_NS_START] = grant & req[B_NS_BEGIN];
        r[B_PAYLOAD] = base[B_PAYLOAD] & req[B_PAYLOAD];
        r[B_PRIO_TAG] = base[B_PRIO_TAG] & cls_prio;
        return r;
    endfunction
endpackage

// File: core/lgc_link_if.sv
// Login link between the port end and the peer (port or fabric) end.
// Both ends run on the same clock; each valid is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
interface lgc_link_if;
    logic d_valid;
    lgc_pkg::lgc_kind_t d_kind;
    logic [31:0] d_w1;
    logic [31:0] d_cls0;
    logic [lgc_pkg::EXT_W-1:0] d_ext;
    logic o_valid;
    lgc_pkg::lgc_kind_t o_kind;
    logic [31:0] o_w1;
    logic [31:0] o_cls0;
    logic [lgc_pkg::EXT_W-1:0] o_ext;

    modport dev (output d_valid, d_kind, d_w1, d_cls0, d_ext,
                 input o_valid, o_kind, o_w1, o_cls0, o_ext);
    modport peer (input d_valid, d_kind, d_w1, d_cls0, d_ext,
                  output o_valid, o_kind, o_w1, o_cls0, o_ext);
endinterface
`default_nettype wire

// File: core/lgc_xchg_track.sv
// Per-exchange transmit sequence count and exchange priority.
// Assumes one exchange tracked at a time, all inputs on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module lgc_xchg_track #(
    parameter int CNT_W = 16,
    parameter int PRIO_W = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic xchg_start,
    input wire logic seq_start,
    input wire logic tx_frame,
    input wire logic cont,
    input wire logic [PRIO_W-1:0] prio_in,
    output logic [CNT_W-1:0] seq_cnt,
    output logic [PRIO_W-1:0] prio
);
    if (CNT_W < 1 || PRIO_W < 1) begin : g_bad
        $error("lgc_xchg_track: widths must be positive");
    end

    // Received frames have no input here, so they cannot move the count
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_cnt <= '0;
            prio <= '0;
        end else begin
            if (xchg_start) begin
                seq_cnt <= '0;
                prio <= prio_in;
            end else if (seq_start && !cont) begin
                seq_cnt <= '0;
            end else if (tx_frame) begin
                seq_cnt <= seq_cnt + CNT_W'(1);
            end
        end
    end
endmodule // lgc_xchg_track
`default_nettype wire

// File: core/lgc_port_end.sv
// Port end of the login codec: APB registers, login request/accept, timers.
// Assumes the peer end answers each request with at most one accept.
`timescale 1ns/1ps
`default_nettype none
module lgc_port_end #(
    parameter int ADDR_W = 8,
    parameter int RTTOV_LONG_CYC = lgc_pkg::RTTOV_LONG_CYC,
    parameter int MS_CYC = lgc_pkg::MS_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    lgc_link_if.dev lnk,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    if (ADDR_W < 5 || RTTOV_LONG_CYC < 1 || MS_CYC < 1) begin : g_bad
        $error("lgc_port_end: ADDR_W below 5 or zero timer count");
    end

    logic [31:0] cfg;
    logic [31:0] edtov_val;
    logic [lgc_pkg::EXT_W-1:0] ext_len;
    lgc_pkg::lgc_state_t st;
    logic [31:0] sent_w1;
    logic sent_flogi;
    logic credit_alt, edtov_ns, rttov_short, cont_seq, ns_sess, bcast;
    logic clk_sync, dhd_peer, app_peer, prio_peer, violation, accepted;
    logic [lgc_pkg::PAY_W-1:0] pay_len;
    logic [31:0] rt_cnt, ed_rem, ed_pre;
    logic rt_run, rt_exp, ed_run, ed_exp;
    logic [15:0] seq_cnt;
    logic [7:0] xprio;
    logic [31:0] rd_data;
    logic rd_hit;
    logic [31:0] loc_w1;

    wire logic setup = psel & ~penable;
    wire logic wr_en = psel & penable & pready & pwrite;
    wire logic [31:0] cmd = (wr_en && paddr == ADDR_W'(lgc_pkg::A_CTRL)) ? pwdata : '0;
    wire logic busy = (st != lgc_pkg::ST_IDLE);
    wire logic in_req = lnk.o_valid & ~lnk.o_kind[1];
    wire logic flogi_in = ~lnk.o_kind[0];
    wire logic acc_match = lnk.o_valid && busy &&
        lnk.o_kind == (sent_flogi ? lgc_pkg::K_FLOGI_ACC : lgc_pkg::K_PLOGI_ACC);
    wire logic go_f = cmd[lgc_pkg::C_FLOGI];
    wire logic go_p = cmd[lgc_pkg::C_PLOGI] & ~go_f;
    wire logic qbc_ok = cfg[lgc_pkg::CFG_RPBC] &
        (cfg[lgc_pkg::CFG_ELS_DIFF] | cfg[lgc_pkg::CFG_MF_UNSUP]);
    wire logic [31:0] loc_cls0 = {8'h00, cfg[lgc_pkg::CFG_CLS_PRIO], 23'h000000};
    wire logic [31:0] rep_w1 = lgc_pkg::lgc_make_acc(flogi_in, loc_w1, lnk.o_w1,
        cfg[lgc_pkg::CFG_NS_GRANT], cfg[lgc_pkg::CFG_CLS_PRIO]);
    wire logic bad_acc = (lnk.o_w1[lgc_pkg::B_NS_START] & flogi_in &
        ~sent_w1[lgc_pkg::B_NS_BEGIN]) |
        (lnk.o_w1[lgc_pkg::B_PAYLOAD] & ~sent_w1[lgc_pkg::B_PAYLOAD]);
    wire logic [15:0] status = {ed_exp, rt_exp, pay_len != lgc_pkg::PAY_W'(lgc_pkg::PAY_SHORT),
        prio_peer, app_peer, dhd_peer, clk_sync, bcast, ns_sess, cont_seq,
        rttov_short, edtov_ns, credit_alt, violation, accepted, busy};

    // Feature bits 27..16 as software set them, gated where a condition applies
    always_comb begin
        loc_w1 = cfg & lgc_pkg::FEAT_MASK;
        loc_w1[lgc_pkg::B_PRIO_TAG] = cfg[lgc_pkg::B_PRIO_TAG] &
            cfg[lgc_pkg::CFG_CLS_PRIO];
        loc_w1[lgc_pkg::B_QBC] = cfg[lgc_pkg::B_QBC] & qbc_ok;
    end

    always_comb begin
        rd_data = '0;
        rd_hit = 1'b1;
        if (paddr == ADDR_W'(lgc_pkg::A_CTRL))
            rd_data = '0;
        else if (paddr == ADDR_W'(lgc_pkg::A_CFG))
            rd_data = cfg;
        else if (paddr == ADDR_W'(lgc_pkg::A_EDTOV))
            rd_data = edtov_val;
        else if (paddr == ADDR_W'(lgc_pkg::A_STATUS))
            rd_data = {16'h0000, status};
        else if (paddr == ADDR_W'(lgc_pkg::A_PAYLEN))
            rd_data = 32'(pay_len);
        else if (paddr == ADDR_W'(lgc_pkg::A_EXTLEN))
            rd_data = 32'(ext_len);
        else if (paddr == ADDR_W'(lgc_pkg::A_XCHG))
            rd_data = {8'h00, xprio, seq_cnt};
        else
            rd_hit = 1'b0;
    end

    // No wait state: the answer is registered during the setup cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            prdata <= (setup && !pwrite) ? rd_data : '0;
            pslverr <= setup & ~rd_hit;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= lgc_pkg::CFG_RST;
            edtov_val <= lgc_pkg::EDTOV_RST;
            ext_len <= lgc_pkg::EXT_RST;
        end else if (wr_en) begin
            if (paddr == ADDR_W'(lgc_pkg::A_CFG))
                cfg <= pwdata;
            else if (paddr == ADDR_W'(lgc_pkg::A_EDTOV))
                edtov_val <= pwdata;
            else if (paddr == ADDR_W'(lgc_pkg::A_EXTLEN))
                ext_len <= pwdata[lgc_pkg::EXT_W-1:0];
        end
    end

    // An incoming request is answered at once and beats a new command
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= lgc_pkg::ST_IDLE;
            lnk.d_valid <= 1'b0;
            lnk.d_kind <= lgc_pkg::K_FLOGI_REQ;
            lnk.d_w1 <= '0;
            lnk.d_cls0 <= '0;
            lnk.d_ext <= '0;
            sent_w1 <= '0;
            sent_flogi <= 1'b0;
        end else begin
            lnk.d_valid <= 1'b0;
            if (in_req) begin
                lnk.d_valid <= 1'b1;
                lnk.d_kind <= flogi_in ? lgc_pkg::K_FLOGI_ACC : lgc_pkg::K_PLOGI_ACC;
                lnk.d_w1 <= rep_w1;
                lnk.d_cls0 <= loc_cls0;
                lnk.d_ext <= ext_len;
            end
            case (st)
                lgc_pkg::ST_IDLE: begin
                    if (!in_req && (go_f || go_p)) begin
                        lnk.d_valid <= 1'b1;
                        lnk.d_kind <= go_f ? lgc_pkg::K_FLOGI_REQ : lgc_pkg::K_PLOGI_REQ;
                        lnk.d_w1 <= loc_w1;
                        lnk.d_cls0 <= loc_cls0;
                        lnk.d_ext <= ext_len;
                        sent_w1 <= loc_w1;
                        sent_flogi <= go_f;
                        st <= lgc_pkg::ST_WAIT;
                    end
                end
                lgc_pkg::ST_WAIT: begin
                    if (acc_match)
                        st <= lgc_pkg::ST_IDLE;
                end
                default: st <= lgc_pkg::ST_IDLE;
            endcase
        end
    end

    // Operating options latched on the matching accept; FLOGI credit and cont_seq come from the sent request
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            {credit_alt, edtov_ns, rttov_short, cont_seq, ns_sess, bcast} <= '0;
            {clk_sync, dhd_peer, app_peer, prio_peer, violation, accepted} <= '0;
            pay_len <= lgc_pkg::PAY_W'(lgc_pkg::PAY_SHORT);
        end else begin
            if (acc_match) begin
                accepted <= 1'b1;
                credit_alt <= flogi_in ? sent_w1[lgc_pkg::B_CREDIT]
                                       : lnk.o_w1[lgc_pkg::B_CREDIT];
                ns_sess <= flogi_in & lnk.o_w1[lgc_pkg::B_NS_START] &
                    sent_w1[lgc_pkg::B_NS_BEGIN];
                bcast <= flogi_in & lnk.o_w1[lgc_pkg::B_BCAST];
                app_peer <= ~flogi_in & lnk.o_w1[lgc_pkg::B_APP_HDR];
                edtov_ns <= lnk.o_w1[lgc_pkg::B_EDTOV_RES];
                rttov_short <= lnk.o_w1[lgc_pkg::B_RTTOV];
                clk_sync <= lnk.o_w1[lgc_pkg::B_CLK_SYNC];
                dhd_peer <= lnk.o_w1[lgc_pkg::B_DHD];
                prio_peer <= lnk.o_w1[lgc_pkg::B_PRIO_TAG] & lnk.o_cls0[lgc_pkg::B_CLS_PRIO];
                if (!flogi_in)
                    cont_seq <= sent_w1[lgc_pkg::B_SEQ_CNT];
                pay_len <= lgc_pkg::lgc_pay_len(lnk.o_w1[lgc_pkg::B_PAYLOAD],
                    lnk.o_ext);
            end
            // A violation in the same cycle as a clear is kept
            if (acc_match && bad_acc)
                violation <= 1'b1;
            else if (cmd[lgc_pkg::C_CLR])
                violation <= 1'b0;
        end
    end

    // Receiver-transmitter timeout, length chosen by the accept
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rt_cnt <= '0;
            rt_run <= 1'b0;
            rt_exp <= 1'b0;
        end else if (cmd[lgc_pkg::C_RTTOV]) begin
            rt_cnt <= rttov_short ? 32'(lgc_pkg::RTTOV_SHORT_CYC - 1)
                                  : 32'(RTTOV_LONG_CYC - 1);
            rt_run <= 1'b1;
            rt_exp <= 1'b0;
        end else if (rt_run) begin
            if (rt_cnt == '0) begin
                rt_run <= 1'b0;
                rt_exp <= 1'b1;
            end else begin
                rt_cnt <= rt_cnt - 32'd1;
            end
        end
    end

    // Error-detect timeout; ns mode burns one clock period per cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ed_rem <= '0;
            ed_pre <= '0;
            ed_run <= 1'b0;
            ed_exp <= 1'b0;
        end else if (cmd[lgc_pkg::C_EDTOV]) begin
            ed_rem <= edtov_val;
            ed_pre <= '0;
            ed_run <= 1'b1;
            ed_exp <= 1'b0;
        end else if (ed_run) begin
            if (edtov_ns) begin
                if (ed_rem <= 32'(lgc_pkg::CLK_NS)) begin
                    ed_run <= 1'b0;
                    ed_exp <= 1'b1;
                end else begin
                    ed_rem <= ed_rem - 32'(lgc_pkg::CLK_NS);
                end
            end else if (ed_rem == '0) begin
                ed_run <= 1'b0;
                ed_exp <= 1'b1;
            end else if (ed_pre == 32'(MS_CYC - 1)) begin
                ed_pre <= '0;
                ed_rem <= ed_rem - 32'd1;
            end else begin
                ed_pre <= ed_pre + 32'd1;
            end
        end
    end

    lgc_xchg_track #(.CNT_W(16), .PRIO_W(8)) lgc_xchg_track_i (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .xchg_start(cmd[lgc_pkg::C_XSTART]),
        .seq_start(cmd[lgc_pkg::C_SEQ]),
        .tx_frame(cmd[lgc_pkg::C_TX]),
        .cont(cont_seq),
        .prio_in(cmd[lgc_pkg::C_PRIO +: 8]),
        .seq_cnt(seq_cnt),
        .prio(xprio)
    );
endmodule // lgc_port_end
`default_nettype wire

// File: core/lgc_peer_end.sv
// Peer end (port or fabric responder) of the login link.
// Assumes user-side inputs come from logic on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module lgc_peer_end (
    input wire logic sys_clk,
    input wire logic rst_n,
    lgc_link_if.peer lnk,
    input wire logic usr_send,
    input wire logic usr_plogi,
    input wire logic [31:0] usr_w1,
    input wire logic [31:0] usr_cls0,
    input wire logic [lgc_pkg::EXT_W-1:0] usr_ext,
    input wire logic [31:0] usr_acc_w1,
    input wire logic usr_ns_grant,
    output logic rx_valid,
    output lgc_pkg::lgc_kind_t rx_kind,
    output logic [31:0] rx_w1,
    output logic [lgc_pkg::PAY_W-1:0] rx_pay_len,
    output logic rx_err
);
    logic [31:0] sent_w1;

    wire logic d_req = lnk.d_valid & ~lnk.d_kind[1];
    wire logic d_flogi = ~lnk.d_kind[0];
    wire logic cls_prio = usr_cls0[lgc_pkg::B_CLS_PRIO];
    wire logic [31:0] acc_w1 = lgc_pkg::lgc_make_acc(d_flogi, usr_acc_w1, lnk.d_w1,
        usr_ns_grant, cls_prio);
    wire logic bad = lnk.d_valid & lnk.d_kind[1] &
        ((d_flogi & lnk.d_w1[lgc_pkg::B_NS_START] & ~sent_w1[lgc_pkg::B_NS_BEGIN]) |
         (lnk.d_w1[lgc_pkg::B_PAYLOAD] & ~sent_w1[lgc_pkg::B_PAYLOAD]));

    // A reply due in the same cycle wins; the send pulse is then dropped
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lnk.o_valid <= 1'b0;
            lnk.o_kind <= lgc_pkg::K_FLOGI_REQ;
            lnk.o_w1 <= '0;
            lnk.o_cls0 <= '0;
            lnk.o_ext <= '0;
            sent_w1 <= '0;
        end else begin
            lnk.o_valid <= 1'b0;
            if (d_req) begin
                lnk.o_valid <= 1'b1;
                lnk.o_kind <= d_flogi ? lgc_pkg::K_FLOGI_ACC : lgc_pkg::K_PLOGI_ACC;
                lnk.o_w1 <= acc_w1;
                lnk.o_cls0 <= usr_cls0;
                lnk.o_ext <= usr_ext;
            end else if (usr_send) begin
                lnk.o_valid <= 1'b1;
                lnk.o_kind <= usr_plogi ? lgc_pkg::K_PLOGI_REQ : lgc_pkg::K_FLOGI_REQ;
                lnk.o_w1 <= usr_w1 & {8'hff, cls_prio, 23'h7fffff};
                lnk.o_cls0 <= usr_cls0;
                lnk.o_ext <= usr_ext;
                sent_w1 <= usr_w1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_valid <= 1'b0;
            rx_kind <= lgc_pkg::K_FLOGI_REQ;
            rx_w1 <= '0;
            rx_pay_len <= lgc_pkg::PAY_W'(lgc_pkg::PAY_SHORT);
            rx_err <= 1'b0;
        end else begin
            rx_valid <= lnk.d_valid;
            rx_err <= bad;
            if (lnk.d_valid) begin
                rx_kind <= lnk.d_kind;
                rx_w1 <= lnk.d_w1;
                rx_pay_len <= lgc_pkg::lgc_pay_len(lnk.d_w1[lgc_pkg::B_PAYLOAD],
                    lnk.d_ext);
            end
        end
    end
endmodule // lgc_peer_end
`default_nettype wire

// File: tb/lgc_monitor.sv
// Link checker for the login codec: watches both directions of the link.
// Assumes both ends run on sys_clk, rst_n active low, valids are pulses.
`timescale 1ns/1ps
`default_nettype none
module lgc_monitor (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic d_valid,
    input wire lgc_pkg::lgc_kind_t d_kind,
    input wire logic [31:0] d_w1,
    input wire logic [31:0] d_cls0,
    input wire logic o_valid,
    input wire lgc_pkg::lgc_kind_t o_kind,
    input wire logic [31:0] o_w1,
    input wire logic [31:0] o_cls0
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Requests carry kind bit 1 low
    sequence d_req;
        d_valid && !d_kind[1];
    endsequence
    sequence o_req;
        o_valid && !o_kind[1];
    endsequence
    // Fabric requests that do not ask for a name-server session
    sequence d_fl_nosess;
        d_req ##0 (d_kind == lgc_pkg::K_FLOGI_REQ && !d_w1[lgc_pkg::B_NS_BEGIN]);
    endsequence
    sequence o_fl_nosess;
        o_req ##0 (o_kind == lgc_pkg::K_FLOGI_REQ && !o_w1[lgc_pkg::B_NS_BEGIN]);
    endsequence
    sess_gate_a: assert property (d_fl_nosess |=>
        !(o_valid && o_kind == lgc_pkg::K_FLOGI_ACC && o_w1[lgc_pkg::B_NS_START]))
        else $error("session bit set");
    sess_gate_back_a: assert property (o_fl_nosess |=>
        !(d_valid && d_kind == lgc_pkg::K_FLOGI_ACC && d_w1[lgc_pkg::B_NS_START]))
        else $error("session bit set");
    pay_short_a: assert property (d_req ##0 !d_w1[lgc_pkg::B_PAYLOAD] |=>
        !(o_valid && o_kind[1] && o_w1[lgc_pkg::B_PAYLOAD])) else $error("long payload accept");
    pay_short_back_a: assert property (o_req ##0 !o_w1[lgc_pkg::B_PAYLOAD] |=>
        !(d_valid && d_kind[1] && d_w1[lgc_pkg::B_PAYLOAD])) else $error("long payload accept");
    prio_gate_a: assert property (d_valid && d_w1[lgc_pkg::B_PRIO_TAG] |->
        d_cls0[lgc_pkg::B_CLS_PRIO]) else $error("prio tag");
    prio_gate_back_a: assert property (o_valid && o_w1[lgc_pkg::B_PRIO_TAG] |->
        o_cls0[lgc_pkg::B_CLS_PRIO]) else $error("prio tag");
    acc_kind_a: assert property (d_req |=> o_valid && o_kind[1] &&
        o_kind[0] == $past(d_kind[0])) else $error("accept kind");
    acc_kind_back_a: assert property (o_req |=> d_valid && d_kind[1] &&
        d_kind[0] == $past(o_kind[0])) else $error("accept kind");
endmodule // lgc_monitor
`default_nettype wire

// File: tb/login_common_features_codec_bench.sv
// Bench for the login codec: port end and peer end joined by the link.
// Assumes APB slave answers after one access cycle; shortened timers.
`timescale 1ns/1ps
`default_nettype none
module login_common_features_codec_bench;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, last_err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, usr_w1 = 32'h0, usr_cls0 = 32'h0, usr_acc_w1 = 32'h0;
    logic pready, pslverr, usr_send = 1'b0, usr_plogi = 1'b0, usr_ns_grant = 1'b0;
    logic [15:0] usr_ext = 16'h0003;
    logic rx_valid, rx_err;
    lgc_pkg::lgc_kind_t rx_kind;
    logic [31:0] rx_w1;
    logic [18:0] rx_pay_len;
    int num_errors = 0, check_count = 0;
    lgc_link_if lnk();
    lgc_port_end #(.RTTOV_LONG_CYC(50), .MS_CYC(4)) lgc_port_end_i (.sys_clk, .rst_n,
        .lnk(lnk), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    lgc_peer_end lgc_peer_end_i (.sys_clk, .rst_n, .lnk(lnk), .usr_send, .usr_plogi, .usr_w1,
        .usr_cls0, .usr_ext, .usr_acc_w1, .usr_ns_grant, .rx_valid, .rx_kind, .rx_w1,
        .rx_pay_len, .rx_err);
    lgc_monitor lgc_monitor_i (.sys_clk, .rst_n, .d_valid(lnk.d_valid), .d_kind(lnk.d_kind),
        .d_w1(lnk.d_w1), .d_cls0(lnk.d_cls0), .o_valid(lnk.o_valid), .o_kind(lnk.o_kind),
        .o_w1(lnk.o_w1), .o_cls0(lnk.o_cls0));
    always #25 sys_clk = ~sys_clk;
    task automatic test_done();
        if (num_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Entered just after an edge; ends one edge after release
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(q & mask, exp);
    endtask
    // Accept lands within three cycles of the command
    task automatic login(input logic [31:0] ctl);
        wr(8'(lgc_pkg::A_CTRL), ctl);
        repeat (4) @(posedge sys_clk);
    endtask
    initial begin
        #(50 * 20000);
        num_errors++;
        test_done();
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rd(8'(lgc_pkg::A_CFG), 32'h0, '1);
        rd(8'(lgc_pkg::A_EDTOV), 32'h7d0, '1);
        rd(8'(lgc_pkg::A_PAYLEN), 32'h74, '1);
        rd(8'h1c, 32'h0, '1);
        chk({31'h0, last_err}, 32'h1);
        wr(8'(lgc_pkg::A_EDTOV), 32'h3);
        wr(8'(lgc_pkg::A_CTRL), 32'h0c);
        repeat (20) @(posedge sys_clk);
        rd(8'(lgc_pkg::A_STATUS), 32'h8000, 32'hc000);
        repeat (40) @(posedge sys_clk);
        rd(8'(lgc_pkg::A_STATUS), 32'hc000, 32'hc000);
        wr(8'(lgc_pkg::A_EXTLEN), 32'h3);
        usr_acc_w1 <= 32'h0f9f_0000;
        usr_ns_grant <= 1'b1;
        wr(8'(lgc_pkg::A_CFG), 32'h0403_0000);
        login(32'h1);
        rd(8'(lgc_pkg::A_STATUS), 32'h2182, 32'h21c3);
        rd(8'(lgc_pkg::A_PAYLEN), 32'h10c, '1);
        wr(8'(lgc_pkg::A_CFG), 32'h0);
        login(32'h1);
        rd(8'(lgc_pkg::A_STATUS), 32'h0002, 32'h2083);
        rd(8'(lgc_pkg::A_PAYLEN), 32'h74, '1);
        wr(8'(lgc_pkg::A_CFG), 32'h0c0a_0000);
        login(32'h2);
        rd(8'(lgc_pkg::A_STATUS), 32'h0e7a, 32'h1f7b);
        chk(32'(rx_pay_len), 32'h74);
        wr(8'(lgc_pkg::A_CTRL), 32'h005a_0010);
        for (int i = 0; i < 3; i++) begin
            wr(8'(lgc_pkg::A_CTRL), 32'h40);
        end
        wr(8'(lgc_pkg::A_CTRL), 32'h0011_0020);
        wr(8'(lgc_pkg::A_CTRL), 32'h40);
        rd(8'(lgc_pkg::A_XCHG), 32'h005a_0004, '1);
        // Port asks session and long payload, its buffer report bit gated off by RPBC clear; peer asks neither
        // Peer tags priority without class priority, so its mask must drop it
        wr(8'(lgc_pkg::A_CFG), 32'h0ccb_0000);
        usr_w1 <= 32'h0080_0000;
        usr_send <= 1'b1;
        @(posedge sys_clk);
        usr_send <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk({31'h0, rx_valid}, 32'h1);
        chk({31'h0, rx_err}, 32'h0);
        chk({30'h0, rx_kind}, 32'h2);
        chk(rx_w1 & 32'h08c1_0000, 32'h0);
        test_done();
    end
endmodule // login_common_features_codec_bench
`default_nettype wire
